// *** inc/acs_pkg.sv ***
// Purpose: constants for the conversion mode and update rate sequencer
// Assumes: 20 MHz system clock
// Notes:   a calibration cycle counts as one output-rate period; one period is half the settle time
package acs_pkg;
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned MODE_MSB        = 15;
	localparam int unsigned MODE_LSB        = 13;
	localparam int unsigned RATE_MSB        = 3;
	localparam int unsigned RATE_LSB        = 0;
	localparam logic [15:0] MODE_RESET      = 16'h000A;
	localparam logic [2:0]  MD_CONT         = 3'h0;
	localparam logic [2:0]  MD_SINGLE       = 3'h1;
	localparam logic [2:0]  MD_IDLE         = 3'h2;
	localparam logic [2:0]  MD_PDOWN        = 3'h3;
	localparam logic [2:0]  MD_ZS_INT       = 3'h4;
	localparam logic [2:0]  MD_ZS_SYS       = 3'h6;
	localparam logic [2:0]  MD_FS_SYS       = 3'h7;
	// oscillator settling before a single conversion, in microseconds
	localparam int unsigned OSC_SETTLE_US   = 1000;
	localparam int unsigned OSC_SETTLE_CYC  = OSC_SETTLE_US * (CLK_HZ / 1_000_000);
	// one output-rate period in microseconds is half the settle time
	localparam int unsigned US_PER_MS_HALF  = 500;
	localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int unsigned CNT_W           = 32;

	typedef enum logic [2:0] {
		ACS_OFF,
		ACS_WAKE,
		ACS_CONV,
		ACS_CAL,
		ACS_IDLE
	} acs_state_t;
endpackage

// *** logic/acs_sequencer.sv ***
// Purpose: mode and update-rate sequencer of a sigma-delta converter
// Assumes: mode register writes arrive as a 16-bit word with a one-cycle strobe
// Notes:   the analog path is abstracted to an input sample word taken at period end
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - mode 000 default: convert back to back, store each result
// R2 - ready output goes low whenever a result completes
// R3 - continuous read shifts each new result out on serial clocks
// R4 - host may instead request a read via communication register
// R5 - first result two periods after reset or write, then one per period
// R6 - single mode: 1 ms oscillator wait, two-period conversion, then power-down
// R7 - single result held and ready low until read or new conversion
// R8 - idle holds filter and modulator reset, modulator clock kept running
// R9 - power-down shuts all circuitry, burnout currents and clock output
// R10 - mode 100 measures shorted input over two cycles into offset
// R11 - calibration drives ready high at start, low at finish
// R12 - after any calibration the device enters idle by itself
// R13 - mode 110 measures external zero-scale into offset register
// R14 - mode 111 measures external full-scale into full-scale register
// R15 - four-bit rate code selects output rate and settle time
// R16 - mode select sits in bits 15 to 13 of mode register
// R17 - any mode write resets modulator and filter, ready goes inactive
// R18 - host must not write mode 101 nor unassigned rate codes
// R19 - one calibration cycle lasts one output-rate period
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int unsigned DATA_W     = 24,
	parameter int unsigned SETTLE_DIV = 1   // divides all period counts, for simulation
) (
	input  wire logic              i_mclk,        // 20 MHz clock
	input  wire logic              i_rst_n,       // async reset, active low
	input  wire logic              i_mode_wr,     // mode register write strobe
	input  wire logic [15:0]       i_mode_wdata,  // mode register write word
	input  wire logic              i_cfg_wr,      // configuration register write strobe
	input  wire logic              i_data_rd,     // host has read the data register
	input  wire logic [DATA_W-1:0] i_sample,      // filter output at period end
	output logic [15:0]            o_mode,        // mode register contents
	output logic [DATA_W-1:0]      o_data,        // data register
	output logic [DATA_W-1:0]      o_offset,      // offset coefficient
	output logic [DATA_W-1:0]      o_fullscale,   // full-scale coefficient
	output logic                   o_rdy_n,       // conversion ready, active low
	output logic                   o_result_stb,  // one-cycle pulse per new result
	output logic                   o_mod_rst,     // modulator and filter held in reset
	output logic                   o_mod_clk_en,  // modulator clocks supplied
	output logic                   o_power_on,    // analog, burnout and clock output powered
	output logic                   o_short_in     // internal input short for zero-scale
);
	// ----------------------------------------------------------------
	// rate table
	// ----------------------------------------------------------------
	// settle time in ms; a period is half of it. unassigned codes fall back to 16.7 Hz
	function automatic logic [9:0] settle_ms(input logic [3:0] code);
		unique case (code)
			4'h3:    settle_ms = 10'd16;                         // R15
			4'h4:    settle_ms = 10'd32;
			4'h5:    settle_ms = 10'd40;
			4'h7:    settle_ms = 10'd60;
			4'h9,
			4'hA:    settle_ms = 10'd120;
			4'hB:    settle_ms = 10'd160;
			4'hC:    settle_ms = 10'd200;
			4'hD:    settle_ms = 10'd240;
			4'hE:    settle_ms = 10'd320;
			4'hF:    settle_ms = 10'd480;
			default: settle_ms = 10'd120;                        // R18
		endcase
	endfunction

	logic [15:0]      mode_q;
	acs_state_t       state_q;
	logic [CNT_W-1:0] cnt_q;
	logic             second_q;     // second period of a two-period span
	logic             first_q;      // first result or calibration since reset or the last write still pending
	logic             rdy_n_q;
	logic             stb_q;
	logic [DATA_W-1:0] data_q;
	logic [DATA_W-1:0] off_q;
	logic [DATA_W-1:0] fs_q;
	logic [2:0]       md;
	logic [CNT_W-1:0] period_cyc;
	logic             period_end;
	logic             wake_end;

	assign md         = mode_q[MODE_MSB:MODE_LSB];                // R16
	assign period_cyc = CNT_W'((32'(settle_ms(mode_q[RATE_MSB:RATE_LSB])) * US_PER_MS_HALF * CYC_PER_US)
	                    / SETTLE_DIV);                            // R19
	assign period_end = (cnt_q >= period_cyc - 1'b1);
	assign wake_end   = (cnt_q >= CNT_W'(OSC_SETTLE_CYC / SETTLE_DIV) - 1'b1);

	// ----------------------------------------------------------------
	// mode register
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= MODE_RESET;
		end else if (i_mode_wr) begin
			mode_q <= i_mode_wdata;
		end else if (state_q == ACS_CAL && second_q && period_end) begin
			mode_q[MODE_MSB:MODE_LSB] <= MD_IDLE;                // R12
		end else if (state_q == ACS_CONV && md == MD_SINGLE && second_q && period_end) begin
			mode_q[MODE_MSB:MODE_LSB] <= MD_PDOWN;               // R6
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// a mode write restarts everything; a config write restarts the filter, and only during continuous conversion
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q  <= ACS_CONV;
			cnt_q    <= '0;
			second_q <= 1'b0;
			first_q  <= 1'b1;
		end else if (i_mode_wr) begin                             // R17
			cnt_q    <= '0;
			second_q <= 1'b0;
			first_q  <= 1'b1;
			unique case (i_mode_wdata[MODE_MSB:MODE_LSB])
				MD_CONT:   state_q <= ACS_CONV;
				MD_SINGLE: state_q <= ACS_WAKE;                   // R6
				MD_IDLE:   state_q <= ACS_IDLE;                   // R8
				MD_PDOWN:  state_q <= ACS_OFF;                    // R9
				MD_ZS_INT,
				MD_ZS_SYS,
				MD_FS_SYS: state_q <= ACS_CAL;                    // R11
				default:   state_q <= ACS_IDLE;                   // R18
			endcase
		end else if (i_cfg_wr && state_q == ACS_CONV && md == MD_CONT) begin
			cnt_q    <= '0;                                       // R5
			second_q <= 1'b0;
			first_q  <= 1'b1;
		end else begin
			unique case (state_q)
				ACS_WAKE: begin
					if (wake_end) begin
						state_q <= ACS_CONV;
						cnt_q   <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ACS_CONV, ACS_CAL: begin
					if (!period_end) begin
						cnt_q <= cnt_q + 1'b1;
					end else begin
						cnt_q <= '0;
						if (state_q == ACS_CAL && second_q) begin
							state_q <= ACS_IDLE;                  // R12
						end else if (md == MD_SINGLE && second_q) begin
							state_q <= ACS_OFF;                   // R6
						end else if (first_q && !second_q) begin
							second_q <= 1'b1;                     // R5
						end else begin
							second_q <= 1'b0;
							first_q  <= 1'b0;
						end
					end
				end
				default: cnt_q <= '0;
			endcase
		end
	end

	// a result completes at the end of the second period first, then every period
	logic conv_done;
	logic cal_done;
	// a config write restarts timing only in continuous mode, so it must not swallow a single result
	assign conv_done = (state_q == ACS_CONV) && period_end && !i_mode_wr && !(i_cfg_wr && md == MD_CONT)
	                   && (second_q || !first_q);                 // R1 R5
	assign cal_done  = (state_q == ACS_CAL) && period_end && second_q && !i_mode_wr;

	// ----------------------------------------------------------------
	// results and coefficients
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_q <= '0;
		end else if (conv_done) begin
			data_q <= i_sample;                                   // R1 R7
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			off_q <= '0;
			fs_q  <= '0;
		end else if (cal_done) begin
			if (md == MD_FS_SYS) begin
				fs_q <= i_sample;                                 // R14
			end else begin
				off_q <= i_sample;                                // R10 R13
			end
		end
	end

	// ----------------------------------------------------------------
	// ready indication
	// ----------------------------------------------------------------
	// completion wins over a read in the same cycle so no result is lost
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdy_n_q <= 1'b1;
			stb_q   <= 1'b0;
		end else begin
			stb_q <= conv_done;                                   // R3 R4
			if (conv_done || cal_done) begin
				rdy_n_q <= 1'b0;                                  // R2 R11
			end else if (i_mode_wr || i_cfg_wr || i_data_rd) begin
				rdy_n_q <= 1'b1;                                  // R7 R17
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_mode       = mode_q;
	assign o_data       = data_q;
	assign o_offset     = off_q;
	assign o_fullscale  = fs_q;
	assign o_rdy_n      = rdy_n_q;
	assign o_result_stb = stb_q;
	assign o_mod_rst    = (state_q != ACS_CONV) && (state_q != ACS_CAL); // R8
	assign o_mod_clk_en = (state_q != ACS_OFF);                   // R9
	assign o_power_on   = (state_q != ACS_OFF);                   // R9
	assign o_short_in   = (state_q == ACS_CAL) && (md == MD_ZS_INT); // R10
endmodule

`default_nettype wire

// *** bench/acs_sequencer_sva.sv ***
// Purpose: port assertions for acs_sequencer
// Assumes: one clock, async active-low reset
// Notes:   mode field history kept in helper flops
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_sva
	import acs_pkg::*;
(
	input wire logic        i_mclk,       // clock
	input wire logic        i_rst_n,      // reset
	input wire logic        i_mode_wr,    // mode write
	input wire logic        i_data_rd,    // data read
	input wire logic [15:0] o_mode,       // mode reg
	input wire logic        o_rdy_n,      // ready
	input wire logic        o_result_stb, // result pulse
	input wire logic        o_mod_rst,    // mod reset
	input wire logic        o_mod_clk_en, // mod clocks
	input wire logic        o_power_on,   // power
	input wire logic        o_short_in    // input short
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	logic [2:0] md_q;
	logic       wr_q;
	wire  [2:0] md     = o_mode[15:13];
	// a field change not caused by a write is the device leaving a mode by itself
	wire        md_chg = !wr_q && md != md_q;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			md_q <= 3'h0;
			wr_q <= 1'b0;
		end else begin
			md_q <= md;
			wr_q <= i_mode_wr;
		end
	end
	property p_wr_rdy; i_mode_wr |=> o_rdy_n; endproperty
	a_wr_rdy: assert property (p_wr_rdy) else $error("ready kept after mode write");
	property p_stb_rdy; o_result_stb |-> !o_rdy_n; endproperty
	a_stb_rdy: assert property (p_stb_rdy) else $error("result without ready");
	property p_rd_rel; i_data_rd ##1 !o_result_stb |-> o_rdy_n; endproperty
	a_rd_rel: assert property (p_rd_rel) else $error("ready kept after read");
	property p_idle; md == MD_IDLE && md_q == MD_IDLE |-> o_mod_rst && o_mod_clk_en; endproperty
	a_idle: assert property (p_idle) else $error("idle decode wrong");
	property p_pdown; md == MD_PDOWN && md_q == MD_PDOWN |-> !o_power_on && !o_mod_clk_en; endproperty
	a_pdown: assert property (p_pdown) else $error("power-down decode wrong");
	property p_short; o_short_in |-> md == MD_ZS_INT; endproperty
	a_short: assert property (p_short) else $error("short outside zero-scale");
	property p_cal_idle; md_chg && md_q[2] && md_q != 3'h5 |-> md == MD_IDLE && !o_rdy_n; endproperty
	a_cal_idle: assert property (p_cal_idle) else $error("calibration end wrong");
	property p_single_pd; md_chg && md_q == MD_SINGLE |-> md == MD_PDOWN && !o_rdy_n; endproperty
	a_single_pd: assert property (p_single_pd) else $error("single end wrong");
	c_stb: cover property (o_result_stb);
	c_short: cover property (o_short_in);
	c_cal: cover property (md_chg && md == MD_IDLE);
endmodule
bind acs_sequencer acs_sequencer_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode_wr(i_mode_wr),
	.i_data_rd(i_data_rd), .o_mode(o_mode), .o_rdy_n(o_rdy_n), .o_result_stb(o_result_stb),
	.o_mod_rst(o_mod_rst), .o_mod_clk_en(o_mod_clk_en), .o_power_on(o_power_on), .o_short_in(o_short_in));
`default_nettype wire

// *** bench/acs_host_model.sv ***
// Purpose: host that reads the data register once ready falls
// Assumes: read strobe taken on the edge where it is high
// Notes:   reads only while enabled, so held results stay visible
`timescale 1ns/1ps
`default_nettype none
module acs_host_model #(parameter int unsigned DATA_W = 24) (
	input  wire logic              i_mclk,    // clock
	input  wire logic              i_rst_n,   // reset
	input  wire logic              i_en,      // read enable
	input  wire logic              i_rdy_n,   // ready
	input  wire logic [DATA_W-1:0] i_data,    // data reg
	output logic                   o_data_rd, // read pulse
	output logic [DATA_W-1:0]      o_got      // value read
);
	// one pulse per result, so a read never overlaps the release it causes
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data_rd <= 1'b0;
			o_got     <= '0;
		end else begin
			o_data_rd <= i_en && !i_rdy_n && !o_data_rd;
			if (i_en && !i_rdy_n && !o_data_rd) begin
				o_got <= i_data;
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/acs_sequencer_bench.sv ***
// Purpose: self-checking bench for acs_sequencer
// Assumes: SETTLE_DIV 1000, one period is settle ms times 10 cycles
// Notes:   sample held per test so the stored value is known
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_bench
	import acs_pkg::*;
;
	localparam int unsigned DIV = 1000;
	logic i_mclk = 1'b0, i_rst_n = 1'b0, i_mode_wr = 1'b0, i_cfg_wr = 1'b0, host_en = 1'b0;
	logic i_data_rd, o_rdy_n, o_result_stb, o_mod_rst, o_mod_clk_en, o_power_on, o_short_in;
	logic [15:0] i_mode_wdata = 16'h0000, o_mode;
	logic [23:0] i_sample = 24'h00_0000, o_data, o_offset, o_fullscale, got;
	int err_count = 0, check_count = 0, seed = 32'h32ed, n;
	// unassigned rate codes fall back to 120 ms
	int settle [16] = '{120, 120, 120, 16, 32, 40, 120, 60, 120, 120, 120, 160, 200, 240, 320, 480};
	logic [3:0] codes [11] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
	logic [2:0] cal [3] = '{MD_ZS_INT, MD_ZS_SYS, MD_FS_SYS};
	always #25 i_mclk = ~i_mclk;
	acs_sequencer #(.DATA_W(24), .SETTLE_DIV(DIV)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata), .i_cfg_wr(i_cfg_wr), .i_data_rd(i_data_rd),
		.i_sample(i_sample), .o_mode(o_mode), .o_data(o_data), .o_offset(o_offset), .o_fullscale(o_fullscale),
		.o_rdy_n(o_rdy_n), .o_result_stb(o_result_stb), .o_mod_rst(o_mod_rst), .o_mod_clk_en(o_mod_clk_en),
		.o_power_on(o_power_on), .o_short_in(o_short_in));
	acs_host_model #(.DATA_W(24)) host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_en(host_en), .i_rdy_n(o_rdy_n),
		.i_data(o_data), .o_data_rd(i_data_rd), .o_got(got));
	function automatic int per(input logic [3:0] c);
		return settle[c] * 500 * 20 / DIV;
	endfunction
	task automatic tick;
		@(posedge i_mclk);
		#2;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// edge counts carry a little slack for the registered ready
	task automatic chk_win(input int g, input int e);
		check_count++;
		if (g < e - 2 || g > e + 3) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic pulse(input logic cfg, input logic [15:0] w);
		tick;
		i_cfg_wr = cfg;
		i_mode_wr = !cfg;
		i_mode_wdata = w;
		tick;
		i_cfg_wr = 1'b0;
		i_mode_wr = 1'b0;
	endtask
	task automatic wait_ev(input logic stb, output int cnt);
		cnt = 0;
		do begin
			tick;
			cnt++;
		end while ((stb ? o_result_stb !== 1'b1 : o_rdy_n !== 1'b0) && cnt < 20000);
		if (cnt >= 20000) begin
			err_count++;
			wrap_up;
		end
	endtask
	initial begin
		repeat (12) @(posedge i_mclk);
		#2 i_rst_n = 1'b1;
		chk(o_mode, 16'h000A);
		foreach (codes[k]) begin
			i_sample = 24'($random(seed));
			pulse(1'b0, {12'h000, codes[k]});
			wait_ev(1'b0, n);
			chk_win(n, 2 * per(codes[k]) - 1);
			chk(o_data, i_sample);
			wait_ev(1'b1, n);
			chk_win(n, per(codes[k]));
		end
		pulse(1'b1, 16'h0000);
		wait_ev(1'b0, n);
		chk_win(n, 2 * per(4'hF) - 1);
		$display("rate test done");
		i_sample = 24'($random(seed));
		pulse(1'b0, 16'h2003);
		wait_ev(1'b0, n);
		chk_win(n, 20000 / DIV + 2 * per(4'h3) - 1);
		chk(o_data, i_sample);
		chk(o_mode[15:13], MD_PDOWN);
		chk(o_power_on, 1'b0);
		repeat (40) tick;
		chk(o_rdy_n, 1'b0);
		host_en = 1'b1;
		repeat (4) tick;
		chk(o_rdy_n, 1'b1);
		chk(got, i_sample);
		host_en = 1'b0;
		$display("single test done");
		foreach (cal[k]) begin
			i_sample = 24'($random(seed));
			pulse(1'b0, {cal[k], 13'h0003});
			chk(o_rdy_n, 1'b1);
			chk(o_short_in, cal[k] == MD_ZS_INT);
			wait_ev(1'b0, n);
			chk_win(n, 2 * per(4'h3) - 1);
			chk(cal[k] == MD_FS_SYS ? o_fullscale : o_offset, i_sample);
			chk(o_mode[15:13], MD_IDLE);
			chk({o_mod_rst, o_mod_clk_en}, 2'b11);
		end
		$display("calibration test done");
		// explicit idle and power-down writes: no result may appear in idle, clocks and power follow the mode
		pulse(1'b0, {MD_IDLE, 13'h0003});
		repeat (2 * per(4'h3) + 4) tick;
		chk({o_rdy_n, o_mod_rst, o_mod_clk_en, o_power_on}, 4'hF);
		pulse(1'b0, {MD_PDOWN, 13'h0003});
		chk({o_mod_rst, o_mod_clk_en, o_power_on}, 3'h4);
		$display("idle and power-down test done");
		wrap_up;
	end
endmodule
`default_nettype wire
